// file: common/adc_port_params.svh
// Constants for the converter parallel output port
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH
`define SAMPLE_WIDTH 8
`define PIPE_LATENCY 5
`define CLK_PERIOD_NS 50
`define OE_ENABLE_MAX_NS 40
`define OE_DISABLE_MAX_NS 10
`define PD_ENTER_TYP_NS 133
`define PD_EXIT_TYP_NS 18
`define CONV_PERIOD_MIN_NS 30
`define CONV_PERIOD_MAX_NS 100000
`define CLK_PHASE_MIN_NS 14
`define CODE_ZERO 8'h00
`define CODE_FULL 8'hFF
// Longest times round down, never below one cycle
`define OE_ENABLE_CYC (((`OE_ENABLE_MAX_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`OE_ENABLE_MAX_NS / `CLK_PERIOD_NS))
`define OE_DISABLE_CYC (((`OE_DISABLE_MAX_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`OE_DISABLE_MAX_NS / `CLK_PERIOD_NS))
// Typical times: rounded up, at least one cycle
`define PD_ENTER_CYC ((`PD_ENTER_TYP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PD_EXIT_CYC ((`PD_EXIT_TYP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: common/adc_port_pkg.sv
// Types for the converter parallel output port
package adc_port_pkg;
	typedef logic [7:0] sample_t;
	typedef enum logic [2:0] {
		PWR_RUN = 3'h1,
		PWR_ENTERING = 3'h2,
		PWR_DOWN = 3'h4
	} pwr_state_t;
endpackage

// file: core/adc_parallel_output_port.sv
// Digital output side of an 8-bit pipelined sampling converter

// All timing is counted in whole convert-clock cycles. Power-down entry and exit
// use the typical figures rounded up, so a faster clock never shortens them below
// the analog settling they stand for. The enable and power-down pins are taken as
// synchronous to the convert clock; each float flag stands in for the weak
// pull-down on its pin. A power-down request dropped during entry returns to run
// at once and loses no words. Words that sat in the pipe across a short sleep are
// masked, so the first valid word after wake is always a fresh conversion.
// Limitation: the enable follows its pin at the next rising edge only.
`timescale 1ns/100ps
`include "adc_port_params.svh"
module adc_parallel_output_port #(
	parameter int LATENCY = `PIPE_LATENCY,
	parameter int IN_WIDTH = 10
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Quantizer result, signed two's complement with headroom
	input wire logic signed [IN_WIDTH-1:0] quant_value,
	// Control pins, pull-down modelled by the floating flags
	input wire logic out_enable_n,
	input wire logic out_enable_n_float,
	input wire logic power_down,
	input wire logic power_down_float,
	// Data pins, index 0 is the top bit
	output adc_port_pkg::sample_t sample_out,
	output logic [`SAMPLE_WIDTH-1:0] sample_oe,
	// Status
	output logic sample_valid,
	output logic powered_down
);
	import adc_port_pkg::*;

	// Power-down delays in whole convert-clock cycles
	localparam int ENTER_CYC = `PD_ENTER_CYC;
	localparam int EXIT_CYC = `PD_EXIT_CYC;
	localparam int HALF = 1 << (`SAMPLE_WIDTH - 1);

	// Refuse sizes that the counters and the clamp cannot serve
	if (LATENCY < 1) begin : g_bad_latency
		$error("adc_parallel_output_port: latency below one");
	end
	// One bit of headroom is needed to tell over-range from a wrapped code
	if (IN_WIDTH < `SAMPLE_WIDTH + 1) begin : g_bad_width
		$error("adc_parallel_output_port: input too narrow");
	end
	if ($bits(sample_t) != `SAMPLE_WIDTH) begin : g_bad_word
		$error("adc_parallel_output_port: word type and width disagree");
	end
	// The power-down counters are eight bits wide
	if (ENTER_CYC < 1 || ENTER_CYC > 256) begin : g_bad_enter
		$error("adc_parallel_output_port: entry delay out of range");
	end
	if (EXIT_CYC > 255) begin : g_bad_exit
		$error("adc_parallel_output_port: exit delay out of range");
	end

	// Undriven inputs read as low
	logic oe_n_eff;
	logic pd_eff;
	assign oe_n_eff = out_enable_n_float ? 1'b0 : out_enable_n;
	assign pd_eff = power_down_float ? 1'b0 : power_down;

	// Clamp and offset: code = value + half scale, held to 0..FF
	sample_t coded;
	always_comb begin
		if (quant_value < -HALF) begin
			coded = `CODE_ZERO;
		end else if (quant_value > HALF - 1) begin
			coded = `CODE_FULL;
		end else begin
			coded = sample_t'(quant_value + HALF);
		end
	end

	// Power-down sequencing
	pwr_state_t pstate;
	pwr_state_t next_pstate;
	logic [7:0] pcount;
	logic [7:0] next_pcount;
	logic [7:0] exit_count;
	logic [7:0] next_exit_count;
	always_comb begin
		next_pstate = pstate;
		next_pcount = pcount;
		next_exit_count = (exit_count != 8'h00) ? exit_count - 8'h01 : 8'h00;
		case (pstate)
			PWR_RUN: begin
				if (pd_eff) begin
					next_pstate = PWR_ENTERING;
					next_pcount = 8'(ENTER_CYC - 1);
				end
			end
			PWR_ENTERING: begin
				// Release during entry aborts at once; no words are lost
				if (!pd_eff) begin
					next_pstate = PWR_RUN;
				end else if (pcount == 8'h00) begin
					next_pstate = PWR_DOWN;
				end else begin
					next_pcount = pcount - 8'h01;
				end
			end
			PWR_DOWN: begin
				if (!pd_eff) begin
					next_pstate = PWR_RUN;
					next_exit_count = 8'(EXIT_CYC);
				end
			end
			default: begin
				next_pstate = PWR_RUN;
			end
		endcase
	end

	// Register the power state and its two counters
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pstate <= PWR_RUN;
			pcount <= 8'h00;
			exit_count <= 8'h00;
		end else begin
			pstate <= next_pstate;
			pcount <= next_pcount;
			exit_count <= next_exit_count;
		end
	end

	// Conversion only runs when awake and past the exit delay
	logic convert_run;
	assign convert_run = (pstate != PWR_DOWN) && (exit_count == 8'h00);

	// Refill guard: a short sleep leaves old valid words in the pipe, and
	// those must not come out as fresh samples after wake-up. Valid is held
	// low until LATENCY new conversions have entered, which costs nothing
	// after a long sleep because the pipe has drained by then anyway.
	localparam int REFILL_W = $clog2(LATENCY + 1);
	logic [REFILL_W-1:0] refill;
	logic [REFILL_W-1:0] next_refill;
	always_comb begin
		next_refill = refill;
		if (pstate == PWR_DOWN && next_pstate == PWR_RUN) begin
			next_refill = REFILL_W'(LATENCY);
		end else if (convert_run && refill != '0) begin
			next_refill = refill - REFILL_W'(1);
		end
	end

	// Register the refill count
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			refill <= '0;
		end else begin
			refill <= next_refill;
		end
	end

	// Conversion pipeline, one word in and one out per clock
	sample_t piped;
	logic piped_valid;
	sample_delay_line #(
		.WIDTH(`SAMPLE_WIDTH),
		.DEPTH(LATENCY)
	) u_delay (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.din(coded),
		.din_valid(convert_run),
		.dout(piped),
		.dout_valid(piped_valid)
	);

	// Bit order: pin index 0 is the MSB
	sample_t reordered;
	always_comb begin
		for (int i = 0; i < `SAMPLE_WIDTH; i++) begin
			reordered[i] = piped[`SAMPLE_WIDTH-1-i];
		end
	end

	// Output registers; enable follows the pin within one cycle
	sample_t next_out;
	logic [`SAMPLE_WIDTH-1:0] next_oe;
	logic next_valid;
	logic next_powered_down;
	always_comb begin
		next_out = reordered;
		next_oe = oe_n_eff ? '0 : '1;
		next_powered_down = (next_pstate == PWR_DOWN);
		// Valid drops on the very edge that reports sleep, never a cycle late
		next_valid = piped_valid && convert_run && (refill == '0) && !next_powered_down;
	end

	// Every top-level output comes straight from these flops
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sample_out <= `CODE_ZERO;
			sample_oe <= '0;
			sample_valid <= 1'b0;
			powered_down <= 1'b0;
		end else begin
			sample_out <= next_out;
			sample_oe <= next_oe;
			sample_valid <= next_valid;
			powered_down <= next_powered_down;
		end
	end
endmodule

// file: core/sample_delay_line.sv
// Fixed-latency register pipeline for sample words
`timescale 1ns/100ps
module sample_delay_line #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 5
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Data
	input wire logic [WIDTH-1:0] din,
	input wire logic din_valid,
	output logic [WIDTH-1:0] dout,
	output logic dout_valid
);
	logic [WIDTH-1:0] stage [DEPTH];
	logic [DEPTH-1:0] vld;
	logic [WIDTH-1:0] next_stage [DEPTH];
	logic [DEPTH-1:0] next_vld;

	// Refuse sizes that leave no pipe at all
	if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
		$error("sample_delay_line: bad size");
	end

	// Shift one position per clock
	always_comb begin
		next_stage[0] = din;
		next_vld[0] = din_valid;
		for (int i = 1; i < DEPTH; i++) begin
			next_stage[i] = stage[i-1];
			next_vld[i] = vld[i-1];
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage[i] <= '0;
			end
			vld <= '0;
		end else begin
			stage <= next_stage;
			vld <= next_vld;
		end
	end

	assign dout = stage[DEPTH-1];
	assign dout_valid = vld[DEPTH-1];
endmodule

// file: tb/adc_parallel_output_port_test.sv
// Testbench for the converter output port
`timescale 1ns/100ps
module adc_parallel_output_port_test;
	import adc_port_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic signed [9:0] quant_value = 10'h000;
	logic out_enable_n = 1'b0;
	logic out_enable_n_float = 1'b0;
	logic power_down = 1'b0;
	logic power_down_float = 1'b0;
	sample_t sample_out;
	logic [7:0] sample_oe, word;
	logic sample_valid, powered_down;
	logic [2:0] skip;
	int n_fail = 0;
	int tests_run = 0;
	adc_parallel_output_port dut (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.quant_value(quant_value),
		.out_enable_n(out_enable_n),
		.out_enable_n_float(out_enable_n_float),
		.power_down(power_down),
		.power_down_float(power_down_float),
		.sample_out(sample_out),
		.sample_oe(sample_oe),
		.sample_valid(sample_valid),
		.powered_down(powered_down)
	);
	capture_model model (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.sample_out(sample_out),
		.sample_oe(sample_oe),
		.sample_valid(sample_valid),
		.powered_down(powered_down),
		.word(word),
		.skip(skip)
	);
	// 50 ns period, 25 ns phases
	initial forever #25 ref_clk = ~ref_clk;
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
			n_fail++;
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic sample_t pin_word(logic signed [9:0] v);
		logic [7:0] c;
		c = (v > 127) ? 8'hFF : (v < -128) ? 8'h00 : 8'(v + 128);
		return {<<{c}};
	endfunction
	// Back-to-back words at both ends and beyond them
	task automatic t_codes;
		logic signed [9:0] v[6] = '{-10'sd200, -10'sd128, 10'sd0, 10'sd1, 10'sd127, 10'sd300};
		for (int k = 0; k < 14; k++) begin
			@(negedge ref_clk);
			if (k < 6) quant_value = v[k];
			if (k >= 6 && k < 12) chk("word", sample_out, pin_word(v[k-6]));
		end
		chk("capture", word, 8'hFF);
	endtask
	// Release, float and drive of the data pins
	task automatic t_enable;
		out_enable_n = 1'b1;
		@(negedge ref_clk);
		chk("oe off", sample_oe, 8'h00);
		out_enable_n_float = 1'b1;
		@(negedge ref_clk);
		chk("oe float", sample_oe, 8'hFF);
		out_enable_n_float = 1'b0;
		@(negedge ref_clk);
		out_enable_n = 1'b0;
		@(negedge ref_clk);
		chk("oe on", sample_oe, 8'hFF);
	endtask
	// Floating request ignored, then sleep, wake and refill
	task automatic t_power;
		power_down = 1'b1;
		power_down_float = 1'b1;
		repeat (5) @(negedge ref_clk);
		chk("float pd", {7'h0, powered_down}, 8'h00);
		power_down_float = 1'b0;
		repeat (5) @(negedge ref_clk);
		chk("asleep", {6'h0, powered_down, sample_valid}, 8'h02);
		power_down = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("awake", {6'h0, powered_down, sample_valid}, 8'h00);
		repeat (8) @(negedge ref_clk);
		chk("refilled", {7'h0, sample_valid}, 8'h01);
	endtask
	initial begin
		repeat (6) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (8) @(negedge ref_clk);
		t_codes;
		t_enable;
		t_power;
		end_sim;
	end
	// Tests need about 60 cycles; allow 2000
	initial begin
		#100000;
		n_fail++;
		end_sim;
	end
endmodule

// file: tb/adc_port_sva.sv
// Pin-level assertions for the converter output port
`timescale 1ns/100ps
module adc_port_sva #(parameter int IN_WIDTH = 10) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Inputs
	input wire logic signed [IN_WIDTH-1:0] quant_value,
	input wire logic out_enable_n,
	input wire logic out_enable_n_float,
	input wire logic power_down,
	input wire logic power_down_float,
	// Outputs
	input wire adc_port_pkg::sample_t sample_out,
	input wire logic [7:0] sample_oe,
	input wire logic sample_valid,
	input wire logic powered_down
);
	// Floating pins read low through the pull-downs
	wire en_on = out_enable_n_float | !out_enable_n;
	wire pd_on = power_down & !power_down_float;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Clamped offset code, top bit on index 0
	function automatic logic [7:0] pin_word(logic signed [IN_WIDTH-1:0] v);
		logic [7:0] c;
		c = (v > 127) ? 8'hFF : (v < -128) ? 8'h00 : 8'(v + 128);
		return {<<{c}};
	endfunction
	a_oe_drive: assert property (en_on |=> sample_oe == 8'hFF)
		else $error("pins not driven");
	a_oe_release: assert property (!en_on |=> sample_oe == 8'h00)
		else $error("pins not released");
	a_word_code: assert property (sample_valid |-> sample_out == pin_word($past(quant_value, 6)))
		else $error("wrong word");
	a_sleep_enter: assert property (pd_on [*5] |-> powered_down)
		else $error("no sleep");
	a_sleep_cause: assert property ($rose(powered_down) |-> $past(pd_on, 2))
		else $error("sleep uncalled");
	a_sleep_quiet: assert property (powered_down |-> !sample_valid)
		else $error("valid asleep");
	a_wake_time: assert property (powered_down ##1 !pd_on [*3] |-> !powered_down)
		else $error("slow wake");
	a_wake_refill: assert property ($fell(powered_down) |-> !sample_valid [*5])
		else $error("early valid");
	c_sleep: cover property ($rose(powered_down));
	c_wake: cover property ($fell(powered_down));
	c_full: cover property (sample_valid && sample_out == 8'hFF);
endmodule
bind adc_parallel_output_port adc_port_sva #(.IN_WIDTH(IN_WIDTH)) chk (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.quant_value(quant_value),
	.out_enable_n(out_enable_n),
	.out_enable_n_float(out_enable_n_float),
	.power_down(power_down),
	.power_down_float(power_down_float),
	.sample_out(sample_out),
	.sample_oe(sample_oe),
	.sample_valid(sample_valid),
	.powered_down(powered_down)
);

// file: tb/capture_model.sv
// Capture logic that takes words from the converter pins
`timescale 1ns/100ps
module capture_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Converter pins
	input wire logic [7:0] sample_out,
	input wire logic [7:0] sample_oe,
	input wire logic sample_valid,
	input wire logic powered_down,
	// Captured word, normal bit order
	output logic [7:0] word,
	output logic [2:0] skip
);
	// Words right after start or wake are unsettled, so drop five
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst || powered_down) skip <= 3'h5;
		else if (sample_valid && skip != 3'h0) skip <= skip - 3'h1;
		else if (sample_valid && sample_oe == 8'hFF) word <= {<<{sample_out}};
	end
endmodule
